// file: core/lod_config_status_regs.sv
// How it works
// R1: trim enable bit applies gain and zero trim to the code; clear passes raw.
// R2: loop modulation connects only in four-to-twenty current range when bit set.
// R3: config holds frame check, timeout enable and two-bit period, reset zero.
// R4: twelve-bit variant keeps upper twelve bits; low nibble ignored, reads zero.
// R5: output code is unsigned binary, resets to zero.
// R6: gain trim is unsigned sixteen bits for both outputs, resets to zero.
// R7: zero trim is signed sixteen bits for both outputs, resets to zero.
// R8: writing one to bit zero at 0x56 restores all registers and alarms.
// R9: the soft reset bit clears itself once the reset is done.
// R10: upper fifteen bits of the soft reset register have no effect.
// R11: status is read-only, upper eleven bits read zero.
// R12: an alarm flag sets on its fault and holds until resolved or reset.
// R13: a fault still present next monitoring cycle sets its flag again.
// R14: status bit four shows a frame check failure.
// R15: status bit three shows a host timeout.
// R16: status bit two shows open loop or compliance fault on current output.
// R17: status bit one is high while the code is ramping.
// R18: status bit zero is high while the die is over temperature.
// R19: host keeps config bits ten to seven zero for single output use.
// R20: dual enable drives voltage by main range, current by span field.
// R21: a write changing the main range clears code to the clear level.
// R22: changing the current span field leaves the code untouched.
module lod_config_status_regs
    import lod_pkg::*;
#(
    parameter bit TWELVE_BIT = 1'b0
)
(
    input  wire logic               ref_clk,
    input  wire logic               rst_n,
    input  wire lod_pkg::lod_wr_t   regWrite,
    input  wire logic               rdEn,
    input  wire logic [7:0]         rdAddr,
    input  wire logic               clearLevelSelectPin,
    input  wire logic               frameCheckError,
    input  wire logic               hostTimeoutExpired,
    input  wire logic               currentLoadProblem,
    input  wire logic               dieOverTemp,
    output logic [15:0]             rdData,
    output logic                    rdValid,
    output logic [15:0]             outputCode,
    output lod_pkg::lod_steer_t     steer,
    output logic                    frameCheckEnable,
    output logic                    hostTimeoutEnable,
    output logic [1:0]              hostTimeoutPeriod
);
    lod_soft_state_t softState_reg;
    lod_soft_state_t softState_next;
    logic [15:0]     control_reg;
    logic [15:0]     config_reg;
    logic [15:0]     code_reg;
    logic [15:0]     gain_reg;
    logic [15:0]     zero_reg;
    logic [15:0]     ramp_reg;
    logic [11:0]     rampCount_reg;
    logic [15:0]     monitorCount_reg;
    logic            monitorTick;
    logic            rampTick;
    logic            clearAll;
    logic            softResetHit;
    logic [15:0]     trimmedCode;
    logic [15:0]     rampStep;
    logic [15:0]     statusWord;
    logic [2:0]      newRange;
    logic            rampActive;
    lod_faults_t     faultIn;
    lod_faults_t     flags;

    // low nibble forced to zero in the twelve-bit variant
    function automatic logic [15:0] resMask(input logic [15:0] value);
        resMask = TWELVE_BIT ? (value & LOW_NIBBLE_MASK) : value;
    endfunction

    // code the output falls to after a range change
    function automatic logic [15:0] clearLevel(input logic [2:0] range, input logic sel);
        logic bipolar;
        bipolar = (range == RANGE_BIPOLAR_5) || (range == RANGE_BIPOLAR_10);
        if (range[RANGE_CURRENT_BIT])
            clearLevel = CODE_ZERO_SCALE;                  // low end of current range
        else if (bipolar)
            clearLevel = sel ? CODE_ZERO_SCALE : CODE_MID_SCALE;
        else
            clearLevel = sel ? CODE_MID_SCALE : CODE_ZERO_SCALE;
    endfunction

    function automatic logic writeTo(input lod_wr_t wr, input logic [7:0] addr);
        writeTo = wr.en && (wr.addr == addr);
    endfunction

    // soft reset takes data bit zero only
    assign softResetHit = writeTo(regWrite, ADDR_SOFT_RESET)
                          && regWrite.data[SOFT_RESET_BIT];    // R8 R10
    assign clearAll     = !rst_n || (softState_reg == LOD_SR_CLEAR);
    assign newRange     = regWrite.data[CTL_RANGE_LSB +: 3];

    // soft reset sequencer: one clearing cycle, then back to idle
    always_comb begin
        softState_next = softState_reg;
        unique case (softState_reg)
            LOD_SR_IDLE: begin
                if (softResetHit)
                    softState_next = LOD_SR_CLEAR;         // R8
            end
            LOD_SR_CLEAR: begin
                softState_next = LOD_SR_IDLE;              // R9
            end
            default: begin
                softState_next = LOD_SR_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            softState_reg <= LOD_SR_IDLE;
        else
            softState_reg <= softState_next;
    end

    // control register: range, slew and clear-select live here
    always_ff @(posedge ref_clk) begin
        if (clearAll)
            control_reg <= CONTROL_RESET;                  // R8
        else if (writeTo(regWrite, ADDR_CONTROL))
            control_reg <= regWrite.data;
    end

    // configuration register; reserved bits are never stored
    always_ff @(posedge ref_clk) begin
        if (clearAll)
            config_reg <= CONFIG_RESET;                    // R3 R8
        else if (writeTo(regWrite, ADDR_CONFIG))
            config_reg <= regWrite.data & CFG_WRITABLE_MASK; // R3
    end

    // output code: host writes, and range changes force the clear level
    always_ff @(posedge ref_clk) begin
        if (clearAll)
            code_reg <= CODE_RESET;                        // R5 R8
        else if (writeTo(regWrite, ADDR_CONTROL)
                 && newRange != control_reg[CTL_RANGE_LSB +: 3])
            code_reg <= clearLevel(newRange,
                                   clearLevelSelectPin
                                   | regWrite.data[CTL_CLEAR_LEVEL_SELECT_BIT_BIT]); // R21
        else if (writeTo(regWrite, ADDR_CODE))
            code_reg <= resMask(regWrite.data);            // R4 R5
    end
    // a span write lands in config_reg only and never reaches code_reg  R22

    // trim registers
    always_ff @(posedge ref_clk) begin
        if (clearAll)
            gain_reg <= GAIN_RESET;                        // R6 R8
        else if (writeTo(regWrite, ADDR_GAIN))
            gain_reg <= resMask(regWrite.data);            // R4 R6
    end

    always_ff @(posedge ref_clk) begin
        if (clearAll)
            zero_reg <= ZERO_RESET;                        // R7 R8
        else if (writeTo(regWrite, ADDR_ZERO))
            zero_reg <= resMask(regWrite.data);            // R4 R7
    end

    lod_trim_calc u_trim (
        .ref_clk     (ref_clk),
        .clear       (clearAll),
        .trimEnable  (config_reg[CFG_TRIM_EN_BIT]),
        .twelveBit   (TWELVE_BIT),
        .rawCode     (code_reg),
        .gainTrim    (gain_reg),
        .zeroTrim    (zero_reg),
        .trimmedCode (trimmedCode)
    );

    // ramp pacing: rate field stretches the base period by 1 to 16
    always_ff @(posedge ref_clk) begin
        if (clearAll || rampTick)
            rampCount_reg <= '0;
        else
            rampCount_reg <= rampCount_reg + 12'h001;
    end
    assign rampTick = (rampCount_reg == 12'(({8'h00, control_reg[CTL_RATE_LSB +: 4]}
                                             + 12'h001) * RAMP_BASE_CYCLES - 1));
    assign rampStep = 16'h0001 << control_reg[CTL_STEP_LSB +: 3];

    // ramped code; with slew off the target passes straight through
    always_ff @(posedge ref_clk) begin
        if (clearAll)
            ramp_reg <= CODE_RESET;
        else if (!control_reg[CTL_SLEW_EN_BIT])
            ramp_reg <= trimmedCode;
        else if (rampTick) begin
            if (trimmedCode > ramp_reg)
                ramp_reg <= (trimmedCode - ramp_reg > rampStep)
                            ? ramp_reg + rampStep : trimmedCode;
            else if (trimmedCode < ramp_reg)
                ramp_reg <= (ramp_reg - trimmedCode > rampStep)
                            ? ramp_reg - rampStep : trimmedCode;
        end
    end
    assign rampActive = control_reg[CTL_SLEW_EN_BIT] && (ramp_reg != trimmedCode); // R17

    always_ff @(posedge ref_clk) begin
        if (clearAll)
            outputCode <= CODE_RESET;
        else
            outputCode <= ramp_reg;
    end

    // monitoring interval: flags are re-evaluated once per interval
    always_ff @(posedge ref_clk) begin
        if (clearAll || monitorTick)
            monitorCount_reg <= '0;
        else
            monitorCount_reg <= monitorCount_reg + 16'h0001;
    end
    assign monitorTick = (monitorCount_reg == 16'(MONITOR_CYCLES - 1));

    // frame and timeout faults count only when enabled
    always_comb begin
        faultIn.frameCheckFault  = frameCheckError && config_reg[CFG_FRAME_CHK_BIT]; // R14
        faultIn.hostTimeoutFault = hostTimeoutExpired && config_reg[CFG_TO_EN_BIT];  // R15
        faultIn.currentLoadFault = currentLoadProblem;                               // R16
        faultIn.overtempFault    = dieOverTemp;                                      // R18
    end

    lod_alarm_flags u_alarm (
        .ref_clk     (ref_clk),
        .clear       (clearAll),
        .monitorTick (monitorTick),
        .faultIn     (faultIn),
        .flags       (flags)
    );

    // status word, upper bits tied low
    always_comb begin
        statusWord                 = 16'h0000;             // R11
        statusWord[ST_FRAME_BIT]   = flags.frameCheckFault;  // R14
        statusWord[ST_TIMEOUT_BIT] = flags.hostTimeoutFault; // R15
        statusWord[ST_CURRENT_BIT] = flags.currentLoadFault; // R16
        statusWord[ST_RAMP_BIT]    = rampActive;             // R17
        statusWord[ST_TEMP_BIT]    = flags.overtempFault;    // R18
    end

    // readback one cycle after the request; unmapped and write-only read zero
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rdData  <= 16'h0000;
            rdValid <= 1'b0;
        end else begin
            rdValid <= rdEn;
            if (!rdEn)
                rdData <= 16'h0000;
            else begin
                unique case (rdAddr)
                    ADDR_STATUS:  rdData <= statusWord;    // R11
                    ADDR_CODE:    rdData <= code_reg;      // R4
                    ADDR_CONTROL: rdData <= control_reg;
                    ADDR_CONFIG:  rdData <= config_reg;
                    ADDR_GAIN:    rdData <= gain_reg;
                    ADDR_ZERO:    rdData <= zero_reg;
                    default:      rdData <= 16'h0000;
                endcase
            end
        end
    end

    // output steering; single mode relies on the host keeping bits 10:7 low  R19
    always_ff @(posedge ref_clk) begin
        if (clearAll) begin
            steer <= '0;
        end else if (config_reg[CFG_DUAL_BIT]) begin
            steer.voltageEnable <= control_reg[CTL_OUT_EN_BIT];                      // R20
            steer.currentEnable <= control_reg[CTL_OUT_EN_BIT];                      // R20
            steer.voltageRange  <= control_reg[CTL_RANGE_LSB +: 3];                  // R20
            steer.currentRange  <= {1'b1, config_reg[CFG_SPAN_LSB +: 2]};            // R20
            steer.modulationConnect <= control_reg[CTL_OUT_EN_BIT]
                && config_reg[CFG_LOOP_MOD_BIT]
                && ({1'b1, config_reg[CFG_SPAN_LSB +: 2]} == RANGE_LOOP_4_20);       // R2
        end else begin
            steer.voltageEnable <= control_reg[CTL_OUT_EN_BIT]
                                   && !control_reg[CTL_RANGE_LSB + RANGE_CURRENT_BIT];
            steer.currentEnable <= control_reg[CTL_OUT_EN_BIT]
                                   && control_reg[CTL_RANGE_LSB + RANGE_CURRENT_BIT];
            steer.voltageRange  <= control_reg[CTL_RANGE_LSB +: 3];
            steer.currentRange  <= control_reg[CTL_RANGE_LSB +: 3];
            steer.modulationConnect <= control_reg[CTL_OUT_EN_BIT]
                && config_reg[CFG_LOOP_MOD_BIT]
                && (control_reg[CTL_RANGE_LSB +: 3] == RANGE_LOOP_4_20);             // R2
        end
    end

    // enables handed to the frame checker and timeout logic elsewhere
    always_ff @(posedge ref_clk) begin
        if (clearAll) begin
            frameCheckEnable  <= 1'b0;
            hostTimeoutEnable <= 1'b0;
            hostTimeoutPeriod <= 2'b00;
        end else begin
            frameCheckEnable  <= config_reg[CFG_FRAME_CHK_BIT];         // R3
            hostTimeoutEnable <= config_reg[CFG_TO_EN_BIT];             // R3
            hostTimeoutPeriod <= config_reg[CFG_TO_PERIOD_LSB +: 2];    // R3
        end
    end
endmodule // lod_config_status_regs

// file: core/lod_pkg.sv
package lod_pkg;
    // register addresses on the register access port
    localparam logic [7:0]  ADDR_STATUS        = 8'h00;
    localparam logic [7:0]  ADDR_CODE          = 8'h01;
    localparam logic [7:0]  ADDR_CONTROL       = 8'h55;
    localparam logic [7:0]  ADDR_SOFT_RESET    = 8'h56;
    localparam logic [7:0]  ADDR_CONFIG        = 8'h57;
    localparam logic [7:0]  ADDR_GAIN          = 8'h58;
    localparam logic [7:0]  ADDR_ZERO          = 8'h59;
    // control register fields
    localparam int          CTL_RANGE_LSB      = 0;
    localparam int          CTL_SLEW_EN_BIT    = 4;
    localparam int          CTL_STEP_LSB       = 5;
    localparam int          CTL_RATE_LSB       = 8;
    localparam int          CTL_OUT_EN_BIT     = 12;
    localparam int          CTL_CLEAR_LEVEL_SELECT_BIT_BIT     = 15;
    // configuration register fields
    localparam int          CFG_TO_PERIOD_LSB  = 0;
    localparam int          CFG_TO_EN_BIT      = 2;
    localparam int          CFG_FRAME_CHK_BIT  = 3;
    localparam int          CFG_LOOP_MOD_BIT   = 4;
    localparam int          CFG_TRIM_EN_BIT    = 5;
    localparam int          CFG_DUAL_BIT       = 8;
    localparam int          CFG_SPAN_LSB       = 9;
    localparam logic [15:0] CFG_WRITABLE_MASK  = 16'h07bf;
    localparam int          SOFT_RESET_BIT     = 0;
    // status register fields
    localparam int          ST_TEMP_BIT        = 0;
    localparam int          ST_RAMP_BIT        = 1;
    localparam int          ST_CURRENT_BIT     = 2;
    localparam int          ST_TIMEOUT_BIT     = 3;
    localparam int          ST_FRAME_BIT       = 4;
    // reset values
    localparam logic [15:0] CONTROL_RESET      = 16'h0000;
    localparam logic [15:0] CONFIG_RESET       = 16'h0000;
    localparam logic [15:0] CODE_RESET         = 16'h0000;
    localparam logic [15:0] GAIN_RESET         = 16'h0000;
    localparam logic [15:0] ZERO_RESET         = 16'h0000;
    localparam logic [15:0] LOW_NIBBLE_MASK    = 16'hfff0;
    // range encodings and clear levels
    localparam int          RANGE_CURRENT_BIT  = 2;
    localparam logic [2:0]  RANGE_LOOP_4_20    = 3'h5;
    localparam logic [2:0]  RANGE_BIPOLAR_5    = 3'h2;
    localparam logic [2:0]  RANGE_BIPOLAR_10   = 3'h3;
    localparam logic [15:0] CODE_ZERO_SCALE    = 16'h0000;
    localparam logic [15:0] CODE_MID_SCALE     = 16'h8000;
    localparam logic [16:0] GAIN_OFFSET        = 17'h08000;
    // timing
    localparam int          CLK_PERIOD_NS      = 10;
    localparam int          MONITOR_INTERVAL_NS = 10000;
    localparam int          MONITOR_CYCLES     = MONITOR_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int          RAMP_BASE_NS       = 1000;
    localparam int          RAMP_BASE_CYCLES   = RAMP_BASE_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        LOD_SR_IDLE  = 2'b00,
        LOD_SR_CLEAR = 2'b01
    } lod_soft_state_t;

    typedef struct packed {
        logic        en;
        logic [7:0]  addr;
        logic [15:0] data;
    } lod_wr_t;

    typedef struct packed {
        logic        voltageEnable;
        logic        currentEnable;
        logic [2:0]  voltageRange;
        logic [2:0]  currentRange;
        logic        modulationConnect;
    } lod_steer_t;

    typedef struct packed {
        logic frameCheckFault;
        logic hostTimeoutFault;
        logic currentLoadFault;
        logic overtempFault;
    } lod_faults_t;
endpackage

// file: core/lod_trim_calc.sv
module lod_trim_calc
    import lod_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        clear,
    input  wire logic        trimEnable,
    input  wire logic        twelveBit,
    input  wire logic [15:0] rawCode,
    input  wire logic [15:0] gainTrim,
    input  wire logic [15:0] zeroTrim,
    output logic      [15:0] trimmedCode
);
    logic [32:0] product;
    logic [17:0] scaled;
    logic [17:0] sum;
    logic [15:0] clamped;

    // gain scales by (gain + half)/full, then the signed offset is added
    always_comb begin
        product = {17'h00000, rawCode} * {16'h0000, gainTrim + GAIN_OFFSET};
        scaled  = {1'b0, product[32:16]};
        sum     = scaled + {{2{zeroTrim[15]}}, zeroTrim};
        if (sum[17])
            clamped = 16'h0000;            // below zero scale
        else if (sum[16])
            clamped = 16'hffff;            // above full scale
        else
            clamped = sum[15:0];
    end

    // registered so the multiplier path never meets the ramp logic directly
    always_ff @(posedge ref_clk) begin
        if (clear)
            trimmedCode <= CODE_RESET;
        else if (trimEnable)
            trimmedCode <= twelveBit ? (clamped & LOW_NIBBLE_MASK) : clamped; // R1
        else
            trimmedCode <= rawCode;        // R1
    end
endmodule // lod_trim_calc

// file: core/lod_alarm_flags.sv
module lod_alarm_flags
    import lod_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        clear,
    input  wire logic        monitorTick,
    input  wire lod_faults_t faultIn,
    output lod_faults_t      flags
);
    lod_faults_t seen_reg;

    // faults seen in the current interval
    always_ff @(posedge ref_clk) begin
        if (clear)
            seen_reg <= '0;
        else if (monitorTick)
            seen_reg <= faultIn;
        else
            seen_reg <= seen_reg | faultIn;
    end

    // a flag sets at once and only drops at a tick with no fault seen;
    // the set term is ORed in so a new fault wins over the tick's clear
    always_ff @(posedge ref_clk) begin
        if (clear)
            flags <= '0;                                   // R12
        else if (monitorTick)
            flags <= seen_reg | faultIn;                   // R12 R13
        else
            flags <= flags | faultIn;                      // R12
    end
endmodule // lod_alarm_flags

// file: bench/lod_chk.sv
module lod_chk
    import lod_pkg::*;
(
    input wire logic                ref_clk,
    input wire logic                rst_n,
    input wire lod_pkg::lod_wr_t    regWrite,
    input wire logic                rdEn,
    input wire logic [7:0]          rdAddr,
    input wire logic                currentLoadProblem,
    input wire logic                dieOverTemp,
    input wire logic [15:0]         rdData,
    input wire logic                rdValid,
    input wire lod_pkg::lod_steer_t steer,
    input wire logic                frameCheckEnable,
    input wire logic                hostTimeoutEnable,
    input wire logic [1:0]          hostTimeoutPeriod
);
    // decoded host writes
    logic       wrCfg;
    logic       wrRst;
    logic [3:0] cfgOut;
    assign wrCfg = regWrite.en && (regWrite.addr == ADDR_CONFIG);
    assign wrRst = regWrite.en && (regWrite.addr == ADDR_SOFT_RESET);
    assign cfgOut = {frameCheckEnable, hostTimeoutEnable, hostTimeoutPeriod};

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    a_status_upper_zero: assert property (
        rdEn && rdAddr == ADDR_STATUS |=> rdValid && rdData[15:5] == 11'h000)
        else $error("status upper bits not zero");
    a_trigger_reads_zero: assert property (
        rdEn && rdAddr == ADDR_SOFT_RESET |=> rdValid && rdData == 16'h0000)
        else $error("reset register read nonzero");
    a_config_copy_out: assert property (
        wrCfg |-> ##2 cfgOut == $past(regWrite.data[3:0], 2))
        else $error("config copy wrong");
    a_soft_reset_clears: assert property (
        wrRst && regWrite.data[SOFT_RESET_BIT] |-> ##[2:5] (cfgOut == 4'h0 && steer == '0))
        else $error("soft reset incomplete");
    a_reset_bits_inert: assert property (
        wrRst && !regWrite.data[SOFT_RESET_BIT] |=> $stable({steer, cfgOut}) [*5])
        else $error("reserved reset bits acted");
    a_overtemp_flag_set: assert property (
        rdEn && rdAddr == ADDR_STATUS && dieOverTemp && $past(dieOverTemp)
        |=> rdData[ST_TEMP_BIT]) else $error("overtemp flag missing");
    a_load_flag_set: assert property (
        rdEn && rdAddr == ADDR_STATUS && currentLoadProblem && $past(currentLoadProblem)
        |=> rdData[ST_CURRENT_BIT]) else $error("load fault flag missing");
    a_modulation_range: assert property (
        steer.modulationConnect |-> steer.currentRange == RANGE_LOOP_4_20)
        else $error("modulation outside loop range");
    a_dual_span_range: assert property (
        wrCfg && regWrite.data[CFG_DUAL_BIT] |-> ##2
        steer.currentRange == {1'b1, $past(regWrite.data[10:9], 2)})
        else $error("dual current range wrong");

    // main scenarios reached
    c_soft_reset: cover property (wrRst && regWrite.data[SOFT_RESET_BIT]);
    c_dual_write: cover property (wrCfg && regWrite.data[CFG_DUAL_BIT]);
    c_modulation: cover property (steer.modulationConnect);
endmodule // lod_chk

bind lod_config_status_regs lod_chk u_chk (.*);

// file: bench/lod_host.sv
module lod_host
    import lod_pkg::*;
(
    input  wire logic              ref_clk,
    output lod_pkg::lod_wr_t       regWrite,
    output logic                   rdEn,
    output logic [7:0]             rdAddr,
    input  wire logic [15:0]       rdData,
    input  wire logic              rdValid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {regWrite, rdEn, rdAddr} = '0;
    // one-cycle write; released fields show the inverse
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        regWrite <= '{en: 1'b1, addr: a, data: d};
        @(negedge ref_clk);
        regWrite <= '{en: 1'b0, addr: ~a, data: ~d};
    endtask
    // answer stands for the cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic ok);
        @(negedge ref_clk);
        rdEn <= 1'b1;
        rdAddr <= a;
        @(negedge ref_clk);
        ok = rdValid;
        d = rdData;
        rdEn <= 1'b0;
        rdAddr <= ~a;
    endtask
endmodule // lod_host

// file: bench/loop_dac_config_status_regs_tb_top.sv
module loop_dac_config_status_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import lod_pkg::*;
    logic        ref_clk, rst_n, rdEn, rdValid, frameCheckEnable, hostTimeoutEnable;
    logic        clearLevelSelectPin, frameCheckError, hostTimeoutExpired, currentLoadProblem;
    logic        dieOverTemp;
    lod_wr_t     regWrite;
    logic [7:0]  rdAddr;
    logic [15:0] rdData, outputCode;
    lod_steer_t  steer;
    logic [1:0]  hostTimeoutPeriod;
    int          n_mismatch = 0;
    int          checks_done = 0;

    lod_config_status_regs uut (.*);
    lod_host u_host (.*);

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // no answer is a mismatch too
    task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        u_host.rd(a, d, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk(d, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    function automatic logic [15:0] cfgOut();
        return {12'h000, frameCheckEnable, hostTimeoutEnable, hostTimeoutPeriod};
    endfunction

    task automatic s_regs();
        rdchk(ADDR_CODE, 16'h0000);
        rdchk(ADDR_GAIN, 16'h0000);
        rdchk(ADDR_ZERO, 16'h0000);
        chk(cfgOut(), 16'h0000);
        u_host.wr(ADDR_CODE, 16'hfedc);
        rdchk(ADDR_CODE, 16'hfedc);
        u_host.wr(ADDR_ZERO, 16'h8001);
        rdchk(ADDR_ZERO, 16'h8001);
        u_host.wr(ADDR_STATUS, 16'hffff);
        rdchk(ADDR_STATUS, 16'h0000);
        rdchk(8'h7f, 16'h0000);
        u_host.wr(ADDR_CONFIG, 16'h000e);
        cyc(2);
        chk(cfgOut(), 16'h000e);
    endtask
    // rows: code, gain, zero, expected; both clamps, negative offset
    task automatic s_trim();
        logic [15:0] t [4][4];
        t = '{'{16'h1000, 16'h0000, 16'h0010, 16'h0810},
              '{16'h0010, 16'h0000, 16'hff00, 16'h0000},
              '{16'hffff, 16'hffff, 16'h0000, 16'hffff},
              '{16'h1000, 16'h4000, 16'hfff0, 16'h0bf0}};
        u_host.wr(ADDR_CONFIG, 16'h0020);
        foreach (t[i]) begin
            u_host.wr(ADDR_CODE, t[i][0]);
            u_host.wr(ADDR_GAIN, t[i][1]);
            rdchk(ADDR_GAIN, t[i][1]);
            u_host.wr(ADDR_ZERO, t[i][2]);
            cyc(6);
            chk(outputCode, t[i][3]);
        end
        u_host.wr(ADDR_CONFIG, 16'h0000);
        cyc(6);
        chk(outputCode, 16'h1000);
        u_host.wr(ADDR_CONTROL, 16'h0010);
        u_host.wr(ADDR_CODE, 16'h1002);
        rdchk(ADDR_STATUS, 16'h0002);
        cyc(250);
        rdchk(ADDR_STATUS, 16'h0000);
    endtask
    task automatic s_alarms();
        dieOverTemp = 1'b1;
        currentLoadProblem = 1'b1;
        cyc(2);
        rdchk(ADDR_STATUS, 16'h0005);
        dieOverTemp = 1'b0;
        cyc(2100);
        rdchk(ADDR_STATUS, 16'h0004);
        currentLoadProblem = 1'b0;
        cyc(2100);
        rdchk(ADDR_STATUS, 16'h0000);
        u_host.wr(ADDR_CONFIG, 16'h000c);
        frameCheckError = 1'b1;
        hostTimeoutExpired = 1'b1;
        cyc(1);
        frameCheckError = 1'b0;
        hostTimeoutExpired = 1'b0;
        rdchk(ADDR_STATUS, 16'h0018);
        u_host.wr(ADDR_SOFT_RESET, 16'hfffe);
        cyc(3);
        rdchk(ADDR_STATUS, 16'h0018);
        chk(cfgOut(), 16'h000c);
        u_host.wr(ADDR_SOFT_RESET, 16'h0001);
        cyc(3);
        rdchk(ADDR_STATUS, 16'h0000);
        rdchk(ADDR_CODE, 16'h0000);
        chk(cfgOut(), 16'h0000);
        rdchk(ADDR_SOFT_RESET, 16'h0000);
    endtask
    task automatic s_range();
        u_host.wr(ADDR_CONTROL, 16'h1002);
        rdchk(ADDR_CODE, CODE_MID_SCALE);
        u_host.wr(ADDR_CODE, 16'h1234);
        u_host.wr(ADDR_CONFIG, 16'h0310);
        cyc(2);
        chk({steer.voltageEnable, steer.currentEnable, 11'h000, steer.currentRange}, 16'hc005);
        chk({13'h0000, steer.voltageRange}, 16'h0002);
        chk({15'h0000, steer.modulationConnect}, 16'h0001);
        u_host.wr(ADDR_CONFIG, 16'h0500);
        rdchk(ADDR_CODE, 16'h1234);
        chk({15'h0000, steer.modulationConnect}, 16'h0000);
        clearLevelSelectPin = 1'b1;
        u_host.wr(ADDR_CONTROL, 16'h1003);
        rdchk(ADDR_CODE, CODE_ZERO_SCALE);
        clearLevelSelectPin = 1'b0;
        u_host.wr(ADDR_CONFIG, 16'h0000);
        u_host.wr(ADDR_CONTROL, 16'h1005);
        cyc(2);
        chk({steer.voltageEnable, steer.currentEnable, 11'h000, steer.currentRange}, 16'h4005);
    endtask

    // hang guard
    initial begin
        #2000000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        {clearLevelSelectPin, frameCheckError, hostTimeoutExpired} = 3'b000;
        {currentLoadProblem, dieOverTemp} = 2'b00;
        cyc(20);
        rst_n = 1'b1;
        s_regs();
        s_trim();
        s_alarms();
        s_range();
        complete_run();
    end
endmodule // loop_dac_config_status_regs_tb_top
